// *** design/dss_core.sv ***
`timescale 1ns/1ps
`include "dss_params.svh"

// dual-slope sequencer with lcd display drive
module dss_core
(
   // clock and reset
   input  wire logic          core_clk,
   input  wire logic          rst_b,
   // analogue front-end
   input  wire logic          cmp_in,      // high: integrator output above zero
   output logic               sw_input,    // input switch, signal integrate
   output logic               sw_ref_pos,  // positive reference, negative inputs
   output logic               sw_ref_neg,  // negative reference, positive inputs
   output logic               sw_az,       // auto-zero switches
   // test pin
   input  wire logic          lamp_test,   // high: lamp test
   // display
   output dss_pkg::dss_seg_t  seg_units,
   output dss_pkg::dss_seg_t  seg_tens,
   output dss_pkg::dss_seg_t  seg_hund,
   output logic [1:0]         seg_thou,    // segments b and c of leading 1
   output logic               seg_minus,
   output logic               backplane
);
   import dss_pkg::*;
   // seven-segment decode of one digit
   function automatic dss_seg_t seg7(input dss_bcd_t d);
      case (d)
         4'h0:    seg7 = 7'h3F;
         4'h1:    seg7 = 7'h06;
         4'h2:    seg7 = 7'h5B;
         4'h3:    seg7 = 7'h4F;
         4'h4:    seg7 = 7'h66;
         4'h5:    seg7 = 7'h6D;
         4'h6:    seg7 = 7'h7D;
         4'h7:    seg7 = 7'h07;
         4'h8:    seg7 = 7'h7F;
         4'h9:    seg7 = 7'h6F;
         default: seg7 = 7'h00;
      endcase
   endfunction

   // lcd drive: in phase with backplane when off, inverted when on
   function automatic dss_seg_t lcd(input dss_seg_t on, input logic bp);
      lcd = on ^ {7{bp}};
   endfunction
   logic tick;                         // one count of the divided clock
   dss_div u_div
   (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .tick     (tick)
   );
   // sequencer state
   dss_phase_t  phase,     next_phase;
   logic [11:0] cyc,       next_cyc;      // position in 4000-count cycle
   logic [11:0] ph_cnt,    next_ph_cnt;   // counts within current phase
   logic        pol_neg,   next_pol_neg;  // sampled polarity
   dss_bcd_t    cnt_u,     next_cnt_u;    // decade counters
   dss_bcd_t    cnt_t,     next_cnt_t;
   dss_bcd_t    cnt_h,     next_cnt_h;
   logic        cnt_k,     next_cnt_k;    // thousands digit
   // latched reading
   dss_bcd_t    disp_u,    next_disp_u;
   dss_bcd_t    disp_t,    next_disp_t;
   dss_bcd_t    disp_h,    next_disp_h;
   logic        disp_k,    next_disp_k;
   logic        disp_neg,  next_disp_neg;
   logic        disp_over, next_disp_over;
   // sequencer next state
   always_comb
   begin
      next_phase     = phase;
      next_cyc       = cyc;
      next_ph_cnt    = ph_cnt;
      next_pol_neg   = pol_neg;
      next_cnt_u     = cnt_u;
      next_cnt_t     = cnt_t;
      next_cnt_h     = cnt_h;
      next_cnt_k     = cnt_k;
      next_disp_u    = disp_u;
      next_disp_t    = disp_t;
      next_disp_h    = disp_h;
      next_disp_k    = disp_k;
      next_disp_neg  = disp_neg;
      next_disp_over = disp_over;
      if (tick)
      begin
         // fixed-length cycle, wraps after 4000 counts
         if (cyc == `DSS_CYCLE_COUNTS - 12'd1) // R5
            next_cyc = 12'h000;
         else
            next_cyc = cyc + 12'h001;
         case (phase)
            PH_INT:
            begin
               // fixed integrate period
               if (ph_cnt == `DSS_INT_COUNTS - 12'd1) // R2
               begin
                  next_phase   = PH_DEINT;
                  next_ph_cnt  = 12'h000;
                  // integrator above zero means negative input
                  next_pol_neg = cmp_in; // R14
                  next_cnt_u   = 4'h0;
                  next_cnt_t   = 4'h0;
                  next_cnt_h   = 4'h0;
                  next_cnt_k   = 1'b0;
               end
               else
                  next_ph_cnt = ph_cnt + 12'h001;
            end
            PH_DEINT:
            begin
               if (cmp_in != pol_neg)
               begin
                  // zero crossing: latch count and polarity
                  next_phase     = PH_AZ; // R13
                  next_disp_u    = cnt_u;
                  next_disp_t    = cnt_t;
                  next_disp_h    = cnt_h;
                  next_disp_k    = cnt_k;
                  next_disp_neg  = pol_neg; // R7 R10
                  next_disp_over = 1'b0;
               end
               else if (ph_cnt == `DSS_DEINT_MAX - 12'd1)
               begin
                  // no crossing within 2000 counts: over-range
                  next_phase     = PH_AZ; // R3
                  next_disp_neg  = pol_neg;
                  next_disp_over = 1'b1; // R6
               end
               else
               begin
                  next_ph_cnt = ph_cnt + 12'h001; // R3
                  // cascaded decade counters
                  if (cnt_u == 4'h9)
                  begin
                     next_cnt_u = 4'h0;
                     if (cnt_t == 4'h9)
                     begin
                        next_cnt_t = 4'h0;
                        if (cnt_h == 4'h9)
                        begin
                           next_cnt_h = 4'h0;
                           next_cnt_k = 1'b1;
                        end
                        else
                           next_cnt_h = cnt_h + 4'h1;
                     end
                     else
                        next_cnt_t = cnt_t + 4'h1;
                  end
                  else
                     next_cnt_u = cnt_u + 4'h1;
               end
            end
            PH_AZ:
            begin
               // auto-zero takes whatever de-integrate left
               if (cyc == `DSS_CYCLE_COUNTS - 12'd1) // R4
               begin
                  next_phase  = PH_INT;
                  next_ph_cnt = 12'h000;
               end
            end
            default:
            begin
               next_phase  = PH_AZ;
               next_ph_cnt = 12'h000;
            end
         endcase
      end
   end

   // sequencer registers
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         phase     <= PH_INT;
         cyc       <= 12'h000;
         ph_cnt    <= 12'h000;
         pol_neg   <= 1'b0;
         cnt_u     <= 4'h0;
         cnt_t     <= 4'h0;
         cnt_h     <= 4'h0;
         cnt_k     <= 1'b0;
         disp_u    <= 4'h0;
         disp_t    <= 4'h0;
         disp_h    <= 4'h0;
         disp_k    <= 1'b0;
         disp_neg  <= 1'b0;
         disp_over <= 1'b0;
      end
      else
      begin
         phase     <= next_phase;
         cyc       <= next_cyc;
         ph_cnt    <= next_ph_cnt;
         pol_neg   <= next_pol_neg;
         cnt_u     <= next_cnt_u;
         cnt_t     <= next_cnt_t;
         cnt_h     <= next_cnt_h;
         cnt_k     <= next_cnt_k;
         disp_u    <= next_disp_u;
         disp_t    <= next_disp_t;
         disp_h    <= next_disp_h;
         disp_k    <= next_disp_k;
         disp_neg  <= next_disp_neg;
         disp_over <= next_disp_over;
      end
   end

   // switch network follows the phase
   assign sw_input   = (phase == PH_INT);
   assign sw_ref_pos = (phase == PH_DEINT) && pol_neg;  // R14
   assign sw_ref_neg = (phase == PH_DEINT) && !pol_neg; // R14
   assign sw_az      = (phase == PH_AZ);
   // display drive state
   logic [6:0]  bp_cnt,   next_bp_cnt;    // counts in backplane half period
   logic        bp,       next_bp;
   dss_seg_t    next_seg_u, next_seg_t, next_seg_h;
   logic [1:0]  next_seg_k;
   logic        next_seg_m;
   dss_seg_t    on_u, on_t, on_h;         // lit segments per digit
   logic        on_k, on_m;
   // backplane and segment next values
   always_comb
   begin
      next_bp_cnt = bp_cnt;
      next_bp     = bp;
      if (tick)
      begin
         if (bp_cnt == `DSS_BP_HALF - 7'd1) // R12
         begin
            next_bp_cnt = 7'h00;
            next_bp     = !bp;
         end
         else
            next_bp_cnt = bp_cnt + 7'h01;
      end
      // digits to light
      if (disp_over)
      begin
         on_u = `DSS_SEG_OFF; // R6
         on_t = `DSS_SEG_OFF;
         on_h = `DSS_SEG_OFF;
         on_k = 1'b1;
      end
      else
      begin
         on_u = seg7(disp_u);
         on_t = seg7(disp_t);
         on_h = seg7(disp_h);
         on_k = disp_k;
      end
      on_m = disp_neg; // R7
      if (lamp_test)
      begin
         // every segment on, constant level
         next_seg_u = `DSS_SEG_ALL; // R8 R9
         next_seg_t = `DSS_SEG_ALL;
         next_seg_h = `DSS_SEG_ALL;
         next_seg_k = 2'h3;
         next_seg_m = 1'b1;
      end
      else
      begin
         next_seg_u = lcd(on_u, bp); // R12
         next_seg_t = lcd(on_t, bp);
         next_seg_h = lcd(on_h, bp);
         next_seg_k = {2{on_k ^ bp}};
         next_seg_m = on_m ^ bp;
      end
   end

   // display registers
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         bp_cnt    <= 7'h00;
         bp        <= 1'b0;
         seg_units <= 7'h00;
         seg_tens  <= 7'h00;
         seg_hund  <= 7'h00;
         seg_thou  <= 2'h0;
         seg_minus <= 1'b0;
         backplane <= 1'b0;
      end
      else
      begin
         bp_cnt    <= next_bp_cnt;
         bp        <= next_bp;
         seg_units <= next_seg_u;
         seg_tens  <= next_seg_t;
         seg_hund  <= next_seg_h;
         seg_thou  <= next_seg_k;
         seg_minus <= next_seg_m;
         backplane <= bp;
      end
   end

   // checks
   AST_INT_WINDOW: assert property (@(posedge core_clk) disable iff (!rst_b) // R2
      sw_input |-> (cyc < `DSS_INT_COUNTS))
      else $error("integrate outside first 1000 counts");
   AST_INT_END: assert property (@(posedge core_clk) disable iff (!rst_b) // R2
      (tick && sw_input && cyc == 12'd999) |=> (sw_ref_pos || sw_ref_neg))
      else $error("integrate did not end at count 1000");
   AST_DEINT_WINDOW: assert property (@(posedge core_clk) disable iff (!rst_b) // R3
      (sw_ref_pos || sw_ref_neg) |-> (cyc >= 12'd1000 && cyc < 12'd3000))
      else $error("de-integrate outside its window");
   AST_AZ_WINDOW: assert property (@(posedge core_clk) disable iff (!rst_b) // R4
      sw_az |-> (cyc >= 12'd1000))
      else $error("auto-zero too long");
   AST_CYCLE_WRAP: assert property (@(posedge core_clk) disable iff (!rst_b) // R5
      (tick && cyc == 12'd3999) |=> (cyc == 12'd0 && sw_input))
      else $error("cycle did not restart at 4000 counts");
   AST_REF_PICK: assert property (@(posedge core_clk) disable iff (!rst_b) // R14
      $rose(sw_ref_pos) |-> $past(cmp_in))
      else $error("positive reference for positive input");
   AST_CROSS_END: assert property (@(posedge core_clk) disable iff (!rst_b) // R13
      (tick && phase == PH_DEINT && cmp_in != pol_neg) |=> (sw_az && !disp_over))
      else $error("crossing did not end de-integrate");
   AST_OVER_BLANK: assert property (@(posedge core_clk) disable iff (!rst_b) // R6
      (disp_over && !lamp_test) |=> (seg_units == {7{backplane}}))
      else $error("over-range digit not blanked");
   AST_NO_SIGN: assert property (@(posedge core_clk) disable iff (!rst_b) // R7
      (!disp_neg && !lamp_test) |=> (seg_minus == backplane))
      else $error("sign lit for positive reading");
   AST_LAMP: assert property (@(posedge core_clk) disable iff (!rst_b) // R8
      lamp_test [*3] |-> (seg_units == `DSS_SEG_ALL && $stable(seg_hund)))
      else $error("lamp test not constant all-on");
   AST_BP_TOGGLE: assert property (@(posedge core_clk) disable iff (!rst_b) // R12
      (tick && bp_cnt == 7'd99) |=> ##1 (backplane != $past(backplane)))
      else $error("backplane did not toggle after 100 counts");
endmodule

// *** shared/dss_params.svh ***
// Function
// R1: oscillator divided by four clocks counters
// R2: signal integrate lasts exactly 1000 counts
// R3: de-integrate lasts 0 to 2000 counts
// R4: auto-zero takes remaining 1000 to 3000 counts
// R5: every conversion totals 4000 counts, 16000 clocks
// R6: over-range blanks three digits, shows 1
// R7: minus sign only for negative readings
// R8: lamp test lights every segment, -1888
// R9: lamp test holds segments constant, no square-wave
// R10: zero input reads zero, sign random
// R11: source clock 48kHz gives three conversions/second
// R12: backplane twenty times rate, on segments inverted
// R13: comparator crossing ends de-integrate, latches reading
// R14: integrate end samples polarity, picks opposite reference
`ifndef DSS_PARAMS_SVH
`define DSS_PARAMS_SVH

// oscillator clocks per count
`define DSS_DIV_RATIO      4
// phase lengths in counts
`define DSS_INT_COUNTS     12'd1000
`define DSS_DEINT_MAX      12'd2000
`define DSS_CYCLE_COUNTS   12'd4000
// backplane half period in counts: 40 toggles per 4000-count cycle
`define DSS_BP_HALF        7'd100
// all segments lit
`define DSS_SEG_ALL        7'h7F
`define DSS_SEG_OFF        7'h00

`endif

// *** shared/dss_pkg.sv ***
package dss_pkg;
   // conversion phases
   typedef enum logic [1:0] {
      PH_INT,
      PH_DEINT,
      PH_AZ
   } dss_phase_t;

   // one seven-segment digit, bit 0 = segment a .. bit 6 = segment g
   typedef logic [6:0] dss_seg_t;
   // one decade digit
   typedef logic [3:0] dss_bcd_t;
endpackage

// *** design/dss_div.sv ***
`timescale 1ns/1ps
`include "dss_params.svh"

// divide the oscillator clock by four into a one-cycle count tick
module dss_div
(
   // clock and reset
   input  wire logic core_clk,
   input  wire logic rst_b,
   // count tick
   output logic      tick
);
   logic [1:0] pre;       // prescaler
   logic [1:0] next_pre;  // next prescaler

   // count modulo four
   always_comb
   begin
      next_pre = pre + 2'h1; // R1
   end

   // register prescaler
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
         pre <= 2'h0;
      else
         pre <= next_pre;
   end

   // one tick every fourth clock
   assign tick = (pre == 2'(`DSS_DIV_RATIO - 1)); // R1

   // tick spacing check
   AST_TICK_SPACING: assert property (@(posedge core_clk) disable iff (!rst_b) // R1
      tick |=> !tick [*3] ##1 tick)
      else $error("count tick not every fourth clock");
endmodule

// *** tb/dss_frontend.sv ***
`timescale 1ns/1ps

// integrator and comparator facing the sequencer; a clock of input moves the
// integrator by -vin, a clock of reference by 1000, so an input of v crosses
// zero within a quarter count after v de-integrate counts
module dss_frontend
(
   // clock
   input  wire logic               core_clk,
   // switch controls from the sequencer
   input  wire logic               sw_input,
   input  wire logic               sw_ref_pos,
   input  wire logic               sw_ref_neg,
   input  wire logic               sw_az,
   // input level set by the bench
   input  wire logic signed [15:0] vin,
   // comparator back to the sequencer
   output logic                    cmp_in
);
   logic signed [31:0] integ = 32'sh0;   // integrator charge

   // integrator ramps; auto-zero discharges it
   always @(posedge core_clk)
   begin
      if (sw_az)
         integ <= 32'sh0;
      else if (sw_input)
         integ <= integ - 32'(vin);
      else if (sw_ref_neg)
         integ <= integ + 32'sh3E8;
      else if (sw_ref_pos)
         integ <= integ - 32'sh3E8;
   end

   // comparator: high while the integrator is above zero
   assign cmp_in = (integ > 32'sh0);
endmodule

// *** tb/dual_slope_sequencer_display_tb_top.sv ***
`timescale 1ns/1ps

// bench for the sequencer, driving it through the front-end model
module dual_slope_sequencer_display_tb_top;
   import dss_pkg::*;

   logic               core_clk = 1'b0;     // oscillator
   logic               rst_b    = 1'b0;     // reset, active low
   logic               lamp_test = 1'b0;    // lamp test pin
   logic signed [15:0] vin      = 16'sh0;   // analogue input level
   logic               cmp_in;              // comparator
   logic               sw_input;            // phase switches
   logic               sw_ref_pos;
   logic               sw_ref_neg;
   logic               sw_az;
   dss_seg_t           seg_units;           // display drive
   dss_seg_t           seg_tens;
   dss_seg_t           seg_hund;
   logic [1:0]         seg_thou;
   logic               seg_minus;
   logic               backplane;
   int                 bad_count = 0;       // mismatches
   int                 n_compared = 0;      // comparisons
   int                 cyc_n = 0;           // clock cycles run
   int                 last_start = 0;      // cycle of last integrate start
   int                 last_v = 0;          // last converted input

   // seven-segment on patterns, bit 0 = a
   localparam logic [6:0] SEG_TAB [0:9] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66,
                                           7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};

   // 100 MHz clock, standing in for the oscillator source
   always #5 core_clk = ~core_clk;

   dss_core u_dss_core (
      .core_clk   (core_clk),
      .rst_b      (rst_b),
      .cmp_in     (cmp_in),
      .sw_input   (sw_input),
      .sw_ref_pos (sw_ref_pos),
      .sw_ref_neg (sw_ref_neg),
      .sw_az      (sw_az),
      .lamp_test  (lamp_test),
      .seg_units  (seg_units),
      .seg_tens   (seg_tens),
      .seg_hund   (seg_hund),
      .seg_thou   (seg_thou),
      .seg_minus  (seg_minus),
      .backplane  (backplane)
   );

   dss_frontend u_dss_frontend (
      .core_clk   (core_clk),
      .sw_input   (sw_input),
      .sw_ref_pos (sw_ref_pos),
      .sw_ref_neg (sw_ref_neg),
      .sw_az      (sw_az),
      .vin        (vin),
      .cmp_in     (cmp_in)
   );

   // compare one value, count and report
   task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // print counts and verdict, then stop
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // check the shown reading; an lcd segment is lit when it differs from backplane
   task automatic disp(input int v);
      int m;
      m = (v < 0) ? -v : v;
      if (m > 1999)
      begin
         chk("low_digits", {seg_hund, seg_tens, seg_units} ^ {21{backplane}}, 24'h0);
         chk("lead_one", seg_thou ^ {2{backplane}}, 24'h3);
      end
      else
      begin
         chk("units", seg_units ^ {7{backplane}}, SEG_TAB[m % 10]);
         chk("tens", seg_tens ^ {7{backplane}}, SEG_TAB[(m / 10) % 10]);
         chk("hund", seg_hund ^ {7{backplane}}, SEG_TAB[(m / 100) % 10]);
         chk("lead_one", seg_thou ^ {2{backplane}}, (m > 999) ? 24'h3 : 24'h0);
      end
      chk("minus", seg_minus ^ backplane, (v < 0) ? 24'h1 : 24'h0);
   endtask

   // run one full conversion of input v and judge phases and reading
   task automatic conv(input string nm, input int v);
      int n;
      int m;
      vin = 16'(v);
      m = (v < 0) ? -v : v;
      n = 0;
      while (!sw_input && n < 20000)
      begin
         @(negedge core_clk);
         n++;
      end
      if (last_start != 0)
         chk("cycle_len", 24'(cyc_n - last_start), 24'd16000);
      last_start = cyc_n;
      n = 0;
      while (sw_input && n < 5000)
      begin
         @(negedge core_clk);
         n++;
      end
      chk("int_len", 24'(n), 24'd4000);
      chk("ref_sel", {sw_ref_pos, sw_ref_neg}, (v < 0) ? 24'h2 : 24'h1);
      n = 0;
      while ((sw_ref_pos || sw_ref_neg) && n < 9000)
      begin
         @(negedge core_clk);
         n++;
      end
      chk("deint_len", 24'(n), (m > 1999) ? 24'd8000 : 24'(4 * (m + 1)));
      chk("az_on", sw_az, 24'h1);
      repeat (2) @(negedge core_clk);
      disp(v);
      last_v = v;
      $display("test %s done", nm);
   endtask

   // lamp test: all segments constant high, backplane keeps its 400-clock half period
   task automatic lamp();
      int n;
      logic bp;
      lamp_test = 1'b1;
      repeat (2) @(negedge core_clk);
      chk("lamp_segs", {seg_thou, seg_minus, seg_hund, seg_tens, seg_units}, 24'hFFFFFF);
      bp = backplane;
      n = 0;
      while (backplane === bp && n < 500)
      begin
         @(negedge core_clk);
         n++;
      end
      bp = backplane;
      n = 0;
      while (backplane === bp && n < 500)
      begin
         @(negedge core_clk);
         n++;
      end
      chk("bp_half", 24'(n), 24'd400);
      chk("lamp_const", {seg_thou, seg_minus, seg_hund, seg_tens, seg_units}, 24'hFFFFFF);
      lamp_test = 1'b0;
      repeat (2) @(negedge core_clk);
      disp(last_v);
      $display("test lamp done");
   endtask

   // cycle counter and hang guard
   always @(posedge core_clk)
   begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 100000)
      begin
         bad_count++;
         test_done();
      end
   end

   // main sequence
   initial
   begin
      repeat (4) @(negedge core_clk);
      rst_b = 1'b1;
      while (!sw_az)
         @(negedge core_clk);
      conv("pos_507", 507);
      conv("neg_1999", -1999);
      conv("zero", 0);
      conv("over_pos", 2500);
      conv("over_neg", -2500);
      lamp();
      test_done();
   end
endmodule
